// file: verilog/dect_pkg.sv
`default_nettype none
package dect_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_CH  = 2;
  localparam int SRC_W   = 5;
  localparam int SENSE_W = 3;
  localparam int NUM_SRC = 19;
  localparam int ST_W    = 2;

  // ****************************************
  // event origin codes, shared by all three selectors
  // ****************************************
  localparam logic [SRC_W-1:0] SRC_OFF     = 5'h00;
  localparam logic [SRC_W-1:0] SRC_TICK    = 5'h01;
  localparam logic [SRC_W-1:0] SRC_LINE0   = 5'h02;
  localparam logic [SRC_W-1:0] SRC_UOUT0   = 5'h06;
  localparam logic [SRC_W-1:0] SRC_C0START = 5'h0a;
  localparam logic [SRC_W-1:0] SRC_C0END   = 5'h0c;
  localparam logic [SRC_W-1:0] SRC_LBLK0   = 5'h0e;
  localparam logic [SRC_W-1:0] SRC_EXP_ST  = 5'h10;
  localparam logic [SRC_W-1:0] SRC_EXP_END = 5'h11;
  localparam logic [SRC_W-1:0] SRC_FTW     = 5'h12;

  // ****************************************
  // activation modes
  // ****************************************
  localparam logic [SENSE_W-1:0] SENSE_LVL_LO  = 3'h0;
  localparam logic [SENSE_W-1:0] SENSE_LVL_HI  = 3'h1;
  localparam logic [SENSE_W-1:0] SENSE_FALL    = 3'h2;
  localparam logic [SENSE_W-1:0] SENSE_RISE    = 3'h3;
  localparam logic [SENSE_W-1:0] SENSE_ANY     = 3'h4;

  // ****************************************
  // status codes
  // ****************************************
  localparam logic [ST_W-1:0] STAT_IDLE = 2'h0;
  localparam logic [ST_W-1:0] STAT_WAIT = 2'h1;
  localparam logic [ST_W-1:0] STAT_RUN  = 2'h2;
  localparam logic [ST_W-1:0] STAT_DONE = 2'h3;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_PICK       = 8'h00;
  localparam logic [7:0] OFS_INC_SRC    = 8'h04;
  localparam logic [7:0] OFS_INC_SENSE  = 8'h08;
  localparam logic [7:0] OFS_LAG        = 8'h0c;
  localparam logic [7:0] OFS_RUNLEN     = 8'h10;
  localparam logic [7:0] OFS_LAUNCH_SRC = 8'h14;
  localparam logic [7:0] OFS_LAUNCH_SNS = 8'h18;
  localparam logic [7:0] OFS_CLEAR_SRC  = 8'h1c;
  localparam logic [7:0] OFS_CLEAR_SNS  = 8'h20;
  localparam logic [7:0] OFS_LIVE       = 8'h24;
  localparam logic [7:0] OFS_STATE      = 8'h28;
  localparam logic [7:0] OFS_SNAP       = 8'h2c;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h34;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [SENSE_W-1:0] SENSE_RST = SENSE_RISE;
  localparam logic [3:0]         MASK_RST  = 4'h0;
  localparam int TICK_NS  = 1000;
  localparam int CLK_NS   = 10;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

  // qualify one signal by an activation mode
  function automatic logic sense_hit(input logic now_v, input logic prev_v,
                                     input logic [SENSE_W-1:0] mode);
    logic hit;
    hit = 1'b0;
    case (mode)
      SENSE_LVL_LO: hit = !now_v;
      SENSE_LVL_HI: hit = now_v;
      SENSE_FALL:   hit = prev_v && !now_v;
      SENSE_RISE:   hit = !prev_v && now_v;
      SENSE_ANY:    hit = prev_v != now_v;
      default:      hit = 1'b0;
    endcase
    return hit;
  endfunction

endpackage
`default_nettype wire

// file: verilog/dect_chan.sv
`timescale 1ns/10ps
`default_nettype none
module dect_chan #(
  parameter int CNT_W = 32
) (
  input  wire logic                         clk,          // system clock
  input  wire logic                         rst,          // sync reset
  input  wire logic [dect_pkg::NUM_SRC-1:0] ev_now,       // event vector
  input  wire logic [dect_pkg::NUM_SRC-1:0] ev_prev,      // event vector, last cycle
  input  wire logic [dect_pkg::SRC_W-1:0]   inc_src,      // increment origin
  input  wire logic [dect_pkg::SENSE_W-1:0] inc_sense,    // increment sense
  input  wire logic [dect_pkg::SRC_W-1:0]   launch_src,   // launch origin
  input  wire logic [dect_pkg::SENSE_W-1:0] launch_sense, // launch sense
  input  wire logic [dect_pkg::SRC_W-1:0]   clear_src,    // clear origin
  input  wire logic [dect_pkg::SENSE_W-1:0] clear_sense,  // clear sense
  input  wire logic [CNT_W-1:0]             lag_cnt,      // start lag count
  input  wire logic [CNT_W-1:0]             run_cnt,      // run length count
  output logic      [CNT_W-1:0]             live_q,       // live tally
  output logic      [CNT_W-1:0]             snap_q,       // tally at clear
  output logic      [dect_pkg::ST_W-1:0]    state_code,   // status code
  output logic                              start_q,      // start event pulse
  output logic                              end_q         // end event pulse
);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN, ST_DONE} dect_st_e;

  dect_st_e         st_q, st_d;
  logic [CNT_W-1:0] live_d, snap_d, inc_cnt;
  logic             started_q, started_d, start_d, end_d;
  logic             inc_hit, launch_hit, clear_hit;

  // off and codes past the last origin never fire; widening keeps every index in range
  function automatic logic origin_hit(input logic [dect_pkg::NUM_SRC-1:0] now_v,
                                      input logic [dect_pkg::NUM_SRC-1:0] prev_v,
                                      input logic [dect_pkg::SRC_W-1:0]   src,
                                      input logic [dect_pkg::SENSE_W-1:0] mode);
    logic [31:0] now_w;
    logic [31:0] prev_w;
    now_w  = 32'(now_v);
    prev_w = 32'(prev_v);
    return (src != dect_pkg::SRC_OFF) && (32'(src) < 32'(dect_pkg::NUM_SRC)) &&
           dect_pkg::sense_hit(now_w[src], prev_w[src], mode);
  endfunction

  // pick and qualify each selected origin; code zero never fires
  always_comb
  begin
    inc_hit    = origin_hit(ev_now, ev_prev, inc_src, inc_sense);
    launch_hit = origin_hit(ev_now, ev_prev, launch_src, launch_sense);
    clear_hit  = origin_hit(ev_now, ev_prev, clear_src, clear_sense);
    inc_cnt    = live_q + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  // channel sequence; clear overrides the state and tally updates in its cycle, but start and end pulses still fire
  always_comb
  begin
    st_d      = st_q;
    live_d    = live_q;
    snap_d    = snap_q;
    started_d = started_q;
    start_d   = 1'b0;
    end_d     = 1'b0;
    case (st_q)
      ST_IDLE:
      begin
        live_d    = '0;
        started_d = 1'b0;
        if (inc_src != dect_pkg::SRC_OFF)
          st_d = (launch_src != dect_pkg::SRC_OFF) ? ST_WAIT : ST_RUN;
      end
      ST_WAIT, ST_DONE:
      begin
        if (launch_hit)
        begin
          st_d      = ST_RUN;
          live_d    = '0;
          started_d = 1'b0;
        end
      end
      ST_RUN:
      begin
        if (inc_hit)
        begin
          live_d = inc_cnt;
          if (!started_q && inc_cnt == lag_cnt)
          begin
            start_d   = 1'b1;
            started_d = 1'b1;
          end
          if (inc_cnt == run_cnt)
          begin
            end_d = 1'b1;
            st_d  = ST_DONE;
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // turning the increment off parks the channel; idle then zeroes its tally
    if (inc_src == dect_pkg::SRC_OFF)
      st_d = ST_IDLE;
    if (clear_hit)
    begin
      snap_d = live_q;
      live_d = '0;
      st_d   = ST_IDLE;
    end
  end

  // channel state registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q      <= ST_IDLE;
      live_q    <= '0;
      snap_q    <= '0;
      started_q <= 1'b0;
      start_q   <= 1'b0;
      end_q     <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      live_q    <= live_d;
      snap_q    <= snap_d;
      started_q <= started_d;
      start_q   <= start_d;
      end_q     <= end_d;
    end
  end

  // status encoding
  always_comb
  begin
    case (st_q)
      ST_WAIT: state_code = dect_pkg::STAT_WAIT;
      ST_RUN:  state_code = dect_pkg::STAT_RUN;
      ST_DONE: state_code = dect_pkg::STAT_DONE;
      default: state_code = dect_pkg::STAT_IDLE;
    endcase
  end

endmodule
`default_nettype wire

// file: verilog/dect_top.sv
`timescale 1ns/10ps
`default_nettype none
module dect_top #(
  parameter int CNT_W = 32
) (
  input  wire logic        clk,             // 100 MHz clock
  input  wire logic        rst,             // sync reset, active high
  input  wire logic        hsel,            // slave select
  input  wire logic [31:0] haddr,           // byte address
  input  wire logic [1:0]  htrans,          // transfer type
  input  wire logic        hwrite,          // write not read
  input  wire logic [2:0]  hsize,           // transfer size
  input  wire logic [31:0] hwdata,          // write data
  input  wire logic        hready,          // bus ready
  output logic             hreadyout,       // slave ready
  output logic             hresp,           // always okay
  output logic      [31:0] hrdata,          // read data
  input  wire logic [3:0]  line_in,         // input lines
  input  wire logic [3:0]  user_out_in,     // user outputs
  input  wire logic [1:0]  logic_blk_in,    // logic block outputs
  input  wire logic        exposure_start,  // exposure start
  input  wire logic        exposure_end,    // exposure end
  input  wire logic        frame_trig_wait, // frame trigger wait
  output logic      [1:0]  start_evt,       // channel start pulses
  output logic      [1:0]  end_evt,         // channel end pulses
  output logic             irq              // level interrupt
);

  localparam int NCH = dect_pkg::NUM_CH;
  localparam int SW  = dect_pkg::SRC_W;
  localparam int AW  = dect_pkg::SENSE_W;

  // ****************************************
  // microsecond tick divider
  // ****************************************
  logic [7:0] tick_cnt_q, tick_cnt_d;
  logic       tick_q, tick_d;

  // one-cycle pulse every TICK_CYC clocks
  always_comb
  begin
    tick_d     = 1'b0;
    tick_cnt_d = tick_cnt_q + 8'h01;
    if (tick_cnt_q == 8'(dect_pkg::TICK_CYC - 1))
    begin
      tick_cnt_d = 8'h00;
      tick_d     = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tick_cnt_q <= 8'h00;
      tick_q     <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end

  // ****************************************
  // event vector
  // ****************************************
  logic [dect_pkg::NUM_SRC-1:0] ev_now, ev_prev_q;
  logic [NCH-1:0]               ch_start, ch_end;

  // bit order follows the origin codes; bit 0 is the off code
  assign ev_now = {frame_trig_wait, exposure_end, exposure_start, logic_blk_in,
                   ch_end, ch_start, user_out_in, line_in, tick_q, 1'b0};

  // last-cycle copy for edge modes
  always_ff @(posedge clk)
  begin
    if (rst)
      ev_prev_q <= '0;
    else
      ev_prev_q <= ev_now;
  end

  // ****************************************
  // bus address phase
  // ****************************************
  logic       acc_q, acc_d, wr_q, wr_d, rdwait_q, rdwait_d;
  logic [7:0] adr_q, adr_d;
  logic       take;

  // only whole-word transfers are taken; others finish as no-ops
  assign take = hsel && htrans[1] && hready && (hsize == 3'b010);

  always_comb
  begin
    acc_d    = take;
    wr_d     = take && hwrite;
    adr_d    = take ? {haddr[7:2], 2'b00} : adr_q;
    rdwait_d = take && !hwrite;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc_q    <= 1'b0;
      wr_q     <= 1'b0;
      adr_q    <= 8'h00;
      rdwait_q <= 1'b0;
    end
    else
    begin
      acc_q    <= acc_d;
      wr_q     <= wr_d;
      adr_q    <= adr_d;
      rdwait_q <= rdwait_d;
    end
  end

  // ****************************************
  // configuration and interrupt registers
  // ****************************************
  logic            pick_q, pick_d;
  logic [SW-1:0]   inc_src_q [NCH], inc_src_d [NCH];
  logic [AW-1:0]   inc_sns_q [NCH], inc_sns_d [NCH];
  logic [SW-1:0]   lch_src_q [NCH], lch_src_d [NCH];
  logic [AW-1:0]   lch_sns_q [NCH], lch_sns_d [NCH];
  logic [SW-1:0]   clr_src_q [NCH], clr_src_d [NCH];
  logic [AW-1:0]   clr_sns_q [NCH], clr_sns_d [NCH];
  logic [CNT_W-1:0] lag_q [NCH], lag_d [NCH];
  logic [CNT_W-1:0] run_q [NCH], run_d [NCH];
  logic [3:0]      ist_q, ist_d, imask_q, imask_d;
  logic            irq_d;
  logic            wen;

  // write lands at the end of the data phase
  assign wen = acc_q && wr_q;

  always_comb
  begin
    pick_d    = pick_q;
    inc_src_d = inc_src_q;
    inc_sns_d = inc_sns_q;
    lch_src_d = lch_src_q;
    lch_sns_d = lch_sns_q;
    clr_src_d = clr_src_q;
    clr_sns_d = clr_sns_q;
    lag_d     = lag_q;
    run_d     = run_q;
    imask_d   = imask_q;
    ist_d     = ist_q;
    if (wen)
    begin
      case (adr_q)
        dect_pkg::OFS_PICK:      pick_d = hwdata[0];
        dect_pkg::OFS_INC_SRC:   inc_src_d[pick_q] = hwdata[SW-1:0];
        dect_pkg::OFS_INC_SENSE: inc_sns_d[pick_q] = hwdata[AW-1:0];
        dect_pkg::OFS_LAG:       lag_d[pick_q] = hwdata[CNT_W-1:0];
        dect_pkg::OFS_RUNLEN:    run_d[pick_q] = hwdata[CNT_W-1:0];
        dect_pkg::OFS_LAUNCH_SRC:
        begin
          lch_src_d[pick_q] = hwdata[SW-1:0];
          if (hwdata[SW-1:0] != dect_pkg::SRC_OFF)
            clr_src_d[pick_q] = dect_pkg::SRC_OFF;
        end
        dect_pkg::OFS_LAUNCH_SNS: lch_sns_d[pick_q] = hwdata[AW-1:0];
        dect_pkg::OFS_CLEAR_SRC:
        begin
          clr_src_d[pick_q] = hwdata[SW-1:0];
          if (hwdata[SW-1:0] != dect_pkg::SRC_OFF)
            lch_src_d[pick_q] = dect_pkg::SRC_OFF;
        end
        dect_pkg::OFS_CLEAR_SNS: clr_sns_d[pick_q] = hwdata[AW-1:0];
        dect_pkg::OFS_IRQ_STAT:  ist_d = ist_q & ~hwdata[3:0];
        dect_pkg::OFS_IRQ_MASK:  imask_d = hwdata[3:0];
        default: ;
      endcase
    end
    // set after clear so a same-cycle event is never lost
    ist_d = ist_d | {ch_end, ch_start};
    irq_d = |(ist_q & imask_q);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pick_q  <= 1'b0;
      ist_q   <= 4'h0;
      imask_q <= dect_pkg::MASK_RST;
      irq     <= 1'b0;
      for (int i = 0; i < NCH; i++)
      begin
        inc_src_q[i] <= dect_pkg::SRC_OFF;
        inc_sns_q[i] <= dect_pkg::SENSE_RST;
        lch_src_q[i] <= dect_pkg::SRC_OFF;
        lch_sns_q[i] <= dect_pkg::SENSE_RST;
        clr_src_q[i] <= dect_pkg::SRC_OFF;
        clr_sns_q[i] <= dect_pkg::SENSE_RST;
        lag_q[i]     <= '0;
        run_q[i]     <= '0;
      end
    end
    else
    begin
      pick_q    <= pick_d;
      ist_q     <= ist_d;
      imask_q   <= imask_d;
      irq       <= irq_d;
      inc_src_q <= inc_src_d;
      inc_sns_q <= inc_sns_d;
      lch_src_q <= lch_src_d;
      lch_sns_q <= lch_sns_d;
      clr_src_q <= clr_src_d;
      clr_sns_q <= clr_sns_d;
      lag_q     <= lag_d;
      run_q     <= run_d;
    end
  end

  // ****************************************
  // channels
  // ****************************************
  logic [CNT_W-1:0]         live_w [NCH];
  logic [CNT_W-1:0]         snap_w [NCH];
  logic [dect_pkg::ST_W-1:0] stat_w [NCH];

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    dect_chan #(.CNT_W(CNT_W)) u_chan (
      .clk          (clk),
      .rst          (rst),
      .ev_now       (ev_now),
      .ev_prev      (ev_prev_q),
      .inc_src      (inc_src_q[g]),
      .inc_sense    (inc_sns_q[g]),
      .launch_src   (lch_src_q[g]),
      .launch_sense (lch_sns_q[g]),
      .clear_src    (clr_src_q[g]),
      .clear_sense  (clr_sns_q[g]),
      .lag_cnt      (lag_q[g]),
      .run_cnt      (run_q[g]),
      .live_q       (live_w[g]),
      .snap_q       (snap_w[g]),
      .state_code   (stat_w[g]),
      .start_q      (ch_start[g]),
      .end_q        (ch_end[g])
    );
  end

  assign start_evt = ch_start;
  assign end_evt   = ch_end;

  // ****************************************
  // read data and ready
  // ****************************************
  logic [31:0] rd_d;
  logic        ready_d;

  // reads take one wait state so hrdata can come from a flop
  always_comb
  begin
    rd_d    = hrdata;
    ready_d = !rdwait_d;
    if (rdwait_q)
    begin
      rd_d = 32'h0000_0000;
      case (adr_q)
        dect_pkg::OFS_PICK:       rd_d[0] = pick_q;
        dect_pkg::OFS_INC_SRC:    rd_d[SW-1:0] = inc_src_q[pick_q];
        dect_pkg::OFS_INC_SENSE:  rd_d[AW-1:0] = inc_sns_q[pick_q];
        dect_pkg::OFS_LAG:        rd_d[CNT_W-1:0] = lag_q[pick_q];
        dect_pkg::OFS_RUNLEN:     rd_d[CNT_W-1:0] = run_q[pick_q];
        dect_pkg::OFS_LAUNCH_SRC: rd_d[SW-1:0] = lch_src_q[pick_q];
        dect_pkg::OFS_LAUNCH_SNS: rd_d[AW-1:0] = lch_sns_q[pick_q];
        dect_pkg::OFS_CLEAR_SRC:  rd_d[SW-1:0] = clr_src_q[pick_q];
        dect_pkg::OFS_CLEAR_SNS:  rd_d[AW-1:0] = clr_sns_q[pick_q];
        dect_pkg::OFS_LIVE:       rd_d[CNT_W-1:0] = live_w[pick_q];
        dect_pkg::OFS_STATE:      rd_d[dect_pkg::ST_W-1:0] = stat_w[pick_q];
        dect_pkg::OFS_SNAP:       rd_d[CNT_W-1:0] = snap_w[pick_q];
        dect_pkg::OFS_IRQ_STAT:   rd_d[3:0] = ist_q;
        dect_pkg::OFS_IRQ_MASK:   rd_d[3:0] = imask_q;
        default:                  rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hrdata    <= rd_d;
      hreadyout <= ready_d;
      hresp     <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: tb/dect_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dect_props (
  input wire logic        clk,       // clock
  input wire logic        rst,       // sync reset
  input wire logic        hsel,      // slave select
  input wire logic [1:0]  htrans,    // transfer type
  input wire logic        hwrite,    // write not read
  input wire logic [2:0]  hsize,     // transfer size
  input wire logic        hready,    // bus ready
  input wire logic        hreadyout, // slave ready
  input wire logic        hresp,     // response
  input wire logic [31:0] hrdata,    // read data
  input wire logic [1:0]  start_evt, // start pulses
  input wire logic [1:0]  end_evt,   // end pulses
  input wire logic        irq        // interrupt
);
  // ****************************************
  // accepted transfers
  // ****************************************
  logic rd_take;
  logic wr_take;
  // narrow sizes are ignored by the slave, so only word transfers count
  assign rd_take = hsel && htrans[1] && hready && !hwrite && (hsize == 3'b010);
  assign wr_take = hsel && htrans[1] && hready && hwrite && (hsize == 3'b010);

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);

  // a read answers after exactly one wait cycle
  sequence s_wait_ready;
    !hreadyout ##1 hreadyout;
  endsequence

  // ****************************************
  // properties
  // ****************************************
  a_resp_okay: assert property (!hresp) else $error("bus response not okay");
  a_read_wait: assert property (rd_take |=> s_wait_ready) else $error("read wait wrong");
  a_write_nowait: assert property (wr_take |=> hreadyout) else $error("write stalled");
  a_wait_cause: assert property ($fell(hreadyout) |-> $past(rd_take)) else $error("stray wait");
  a_rdata_hold: assert property (!$rose(hreadyout) |-> $stable(hrdata)) else $error("read data moved");
  a_end_single0: assert property (end_evt[0] |=> !end_evt[0]) else $error("end pulse 0 too long");
  a_end_single1: assert property (end_evt[1] |=> !end_evt[1]) else $error("end pulse 1 too long");
  a_reset_clean: assert property ($fell(rst) |-> (hreadyout && hrdata == 32'h0000_0000 && start_evt == 2'b00
    && end_evt == 2'b00 && !irq)) else $error("outputs not quiet after reset");
endmodule
`default_nettype wire

// file: tb/dect_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dect_top_tb;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [18:0] ev;
  logic [1:0]  start_evt;
  logic [1:0]  end_evt;
  logic        irq;
  logic [31:0] q;
  logic [31:0] b;
  int          err_count;
  int          check_count;
  int          codes[13] = '{2, 3, 4, 5, 6, 7, 8, 9, 14, 15, 16, 17, 18};
  int          gain[6] = '{3, 3, 1, 1, 2, 0};

  // clock, 10 ns period
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // event bit index equals the origin code that selects it
  dect_top dut_u (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .line_in(ev[5:2]), .user_out_in(ev[9:6]), .logic_blk_in(ev[15:14]), .exposure_start(ev[16]),
    .exposure_end(ev[17]), .frame_trig_wait(ev[18]), .start_evt(start_evt), .end_evt(end_evt), .irq(irq)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one word transfer; entered just after a rising edge, waits for ready with no assumed latency
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0000_00, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask

  // drive one event line to lvl for n cycles, then back
  task automatic hit(input int idx, input int n, input logic lvl);
    ev[idx] <= lvl;
    repeat (n) @(posedge clk);
    ev[idx] <= !lvl;
    @(posedge clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    ev = 19'h0_0000;
    err_count = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(8'h08, 32'h0000_0003);
    rd(8'h18, 32'h0000_0003);
    rd(8'h20, 32'h0000_0003);
    rd(8'h28, 32'h0000_0000);
    rd(8'h34, 32'h0000_0000);
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h3c, 32'h0000_0000);
    wr(8'h00, 32'h0000_0003);
    rd(8'h00, 32'h0000_0001);
    wr(8'h00, 32'h0000_0000);
    $display("test reset_values done");
    // every external input origin (not the tick or the channel events) counts three level-high cycles
    wr(8'h08, 32'h0000_0001);
    foreach (codes[i])
    begin
      wr(8'h04, codes[i]);
      bus(1'b0, 8'h24, 32'h0000_0000);
      b = q;
      hit(codes[i], 3, 1'b1);
      rd(8'h24, b + 32'h0000_0003);
    end
    $display("test origins done");
    // each sense against a three-cycle excursion from its idle level; code 5 never hits
    for (int m = 0; m < 6; m++)
    begin
      wr(8'h04, 32'h0000_0000);
      ev[2] <= (m == 0);
      wr(8'h08, m);
      wr(8'h04, 32'h0000_0002);
      bus(1'b0, 8'h24, 32'h0000_0000);
      b = q;
      hit(2, 3, (m != 0));
      rd(8'h24, b + gain[m]);
    end
    $display("test senses done");
    // channel 0 counts channel 1 end events; channel 1 runs lag 2, length 4
    wr(8'h08, 32'h0000_0003);
    wr(8'h04, 32'h0000_000d);
    bus(1'b0, 8'h24, 32'h0000_0000);
    b = q;
    wr(8'h00, 32'h0000_0001);
    wr(8'h0c, 32'h0000_0002);
    wr(8'h10, 32'h0000_0004);
    wr(8'h04, 32'h0000_0003);
    wr(8'h34, 32'h0000_000a);
    for (int i = 1; i <= 4; i++)
    begin
      hit(3, 1, 1'b1);
      chk({28'h000_0000, end_evt, start_evt}, {28'h000_0000, i == 4, 1'b0, i == 2, 1'b0});
    end
    rd(8'h28, 32'h0000_0003);
    rd(8'h24, 32'h0000_0004);
    rd(8'h30, 32'h0000_000a);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(8'h30, 32'h0000_0002);
    rd(8'h30, 32'h0000_0008);
    wr(8'h34, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr(8'h34, 32'h0000_000a);
    wr(8'h30, 32'h0000_0008);
    rd(8'h30, 32'h0000_0000);
    wr(8'h00, 32'h0000_0000);
    rd(8'h24, b + 32'h0000_0001);
    wr(8'h00, 32'h0000_0001);
    $display("test events done");
    // launch and clear exclude each other; clear on a falling edge of line 3
    wr(8'h20, 32'h0000_0002);
    wr(8'h14, 32'h0000_0004);
    wr(8'h1c, 32'h0000_0005);
    rd(8'h14, 32'h0000_0000);
    hit(5, 1, 1'b1);
    rd(8'h2c, 32'h0000_0004);
    rd(8'h24, 32'h0000_0000);
    rd(8'h28, 32'h0000_0002);
    wr(8'h14, 32'h0000_0004);
    rd(8'h1c, 32'h0000_0000);
    repeat (4) hit(3, 1, 1'b1);
    rd(8'h28, 32'h0000_0003);
    wr(8'h18, 32'h0000_0002);
    hit(4, 1, 1'b1);
    rd(8'h24, 32'h0000_0000);
    rd(8'h28, 32'h0000_0002);
    hit(3, 1, 1'b1);
    rd(8'h24, 32'h0000_0001);
    $display("test launch_clear done");
    // channel 0 on the microsecond tick: ten ticks per thousand cycles, then lag 2 and length 20 fire
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0000);
    wr(8'h0c, 32'h0000_0002);
    wr(8'h10, 32'h0000_0014);
    wr(8'h30, 32'h0000_000f);
    wr(8'h04, 32'h0000_0001);
    bus(1'b0, 8'h24, 32'h0000_0000);
    b = q;
    // 997 idle edges put the two data loads exactly 1000 cycles apart
    repeat (997) @(posedge clk);
    rd(8'h24, b + 32'h0000_000a);
    repeat (1000) @(posedge clk);
    rd(8'h28, 32'h0000_0003);
    rd(8'h24, 32'h0000_0014);
    rd(8'h30, 32'h0000_0005);
    $display("test tick done");
    results();
  end

  // hang guard, well beyond the few thousand cycles the tests take
  initial
  begin
    #100_000;
    err_count++;
    results();
  end
endmodule

bind dect_top dect_props chk_u (
  .clk(clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .start_evt(start_evt), .end_evt(end_evt), .irq(irq)
);
`default_nettype wire
